// ### src/mraf_filter.sv
// Receive address filter with indirect register port and frame FIFO
// Behaviour
// R1: Station address is six bytes, byte 0 holds bits 7..0, byte 5 bits 47..40.
// R2: After reset the station address is loaded from the EEPROM value.
// R3: Unicast frame passes on exact address match, bit 5 hash hit or promiscuous, else rejected.
// R4: Promiscuous bit 0 forwards every frame regardless of address; resets to 0.
// R5: All-multicast bit 1 passes every multicast; else hash must hit; resets 0.
// R6: Bit 2 keeps CRC-error frames; clear discards them; resets 0.
// R7: Bit 3 accepts broadcast frames; resets to 1.
// R8: Bit 4 accepts multicast frames whose hash bit is set; resets to 1.
// R9: Bit 5 lets a unicast hash hit count as address match; resets 0.
// R10: Software always writes one to reserved bit 6, which resets to 1.
// R11: Bit 7 runs the MAC; clear stops it and resets the packet buffer.
// R12: All destination bits feed CRC-32; top six bits latched as hash.
// R13: Hash decoded one-of-64 selects a table bit; multicast needs it set.
// R14: Table bit n sits in byte n/8 at position n mod 8.
// R15: Pause frames are always rejected whatever the settings.
// R16: Multicast when bit 0 of the first destination byte is one.
// R17: All-ones destination is broadcast, handled by broadcast acceptance.
// R18: Without promiscuous or all-multicast, multicast needs hash enable and hit.
// R19: CRC-32 standard polynomial, all-ones preset, LSB of each byte first.
`timescale 1ns/100ps
`default_nettype none

module mraf_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("mraf_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp, rp, next_wp, next_rp;
	logic push, pop;

	assign in_ready = (wp - rp) != (AW + 1)'(DEPTH);
	assign out_valid = wp != rp;
	assign out_data = mem[rp[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		next_wp = wp + (AW + 1)'(push);
		next_rp = rp + (AW + 1)'(pop);
		if (flush) begin
			next_wp = '0;
			next_rp = '0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp[AW-1:0]] <= in_data;
		end
	end
endmodule

module mraf_filter #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic ee_load,
	input wire logic [47:0] ee_station_address,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	input wire logic rx_crc_err,
	input wire logic rx_pause,
	output logic pkt_valid,
	input wire logic pkt_ready,
	output logic [7:0] pkt_data,
	output logic pkt_last,
	output logic pkt_accept,
	output logic mac_run
);
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("mraf_filter needs a FIFO of two words or more");
	end
	// Serial CRC, one data bit per step, low bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? mraf_pkg::CRC_POLY : 32'h0000_0000);
		end
		return r;
	endfunction
	// Byte seen through the data register at a given index and position
	function automatic logic [7:0] get_byte(input logic [7:0] base, input logic [3:0] pos,
			input logic [7:0] rc, input logic [47:0] sa, input logic [63:0] ht);
		logic [7:0] b;
		b = 8'h00;
		if (base == mraf_pkg::REG_RCTL && pos == 4'h0) begin
			b = rc;
		end else if (base == mraf_pkg::REG_STATION && int'(pos) < mraf_pkg::STATION_BYTES) begin
			b = sa[{pos[2:0], 3'b000} +: 8];
		end else if (base == mraf_pkg::REG_HASH && int'(pos) < mraf_pkg::HASH_BYTES) begin
			b = ht[{pos[2:0], 3'b000} +: 8];
		end
		return b;
	endfunction
	logic [7:0] rctl, next_rctl;
	logic [47:0] station, next_station;
	logic [63:0] htable, next_htable;
	logic [63:0] stage, next_stage;
	logic [3:0] stage_cnt, next_stage_cnt;
	logic [7:0] rd_base, next_rd_base;
	logic [3:0] rd_pos, next_rd_pos;
	logic [7:0] next_rdata;
	logic idx_wr;
	assign idx_wr = sfr_wr && sfr_addr == mraf_pkg::SFR_INDEX;
	assign mac_run = rctl[mraf_pkg::BIT_RUN];
	always_comb begin
		next_rctl = rctl;
		next_station = station;
		next_htable = htable;
		next_stage = stage;
		next_stage_cnt = stage_cnt;
		next_rd_base = rd_base;
		next_rd_pos = rd_pos;
		// Data writes queue up, lowest byte first
		if (sfr_wr && sfr_addr == mraf_pkg::SFR_DATA && int'(stage_cnt) < mraf_pkg::STAGE_BYTES) begin
			next_stage[{stage_cnt[2:0], 3'b000} +: 8] = sfr_wdata;
			next_stage_cnt = stage_cnt + 4'h1;
		end
		if (idx_wr) begin
			next_stage_cnt = 4'h0;
			next_rd_pos = 4'h0;
			if (sfr_wdata == mraf_pkg::CMD_ABORT || stage_cnt != 4'h0) begin
				next_rd_base = mraf_pkg::CMD_ABORT;
			end else begin
				next_rd_base = sfr_wdata;
			end
			// Queued bytes commit to the indexed register
			if (sfr_wdata != mraf_pkg::CMD_ABORT) begin
				for (int j = 0; j < mraf_pkg::STAGE_BYTES; j++) begin
					if (j < int'(stage_cnt)) begin
						if (sfr_wdata == mraf_pkg::REG_RCTL && j < mraf_pkg::RCTL_BYTES) begin
							next_rctl = stage[j*8 +: 8]; // [R10]
						end
						if (sfr_wdata == mraf_pkg::REG_STATION && j < mraf_pkg::STATION_BYTES) begin
							next_station[j*8 +: 8] = stage[j*8 +: 8]; // [R1]
						end
						if (sfr_wdata == mraf_pkg::REG_HASH && j < mraf_pkg::HASH_BYTES) begin
							next_htable[j*8 +: 8] = stage[j*8 +: 8]; // [R14]
						end
					end
				end
			end
		end else if (sfr_rd && sfr_addr == mraf_pkg::SFR_DATA && rd_pos != 4'hF) begin
			next_rd_pos = rd_pos + 4'h1;
		end
		// EEPROM image wins over a software write in the same cycle
		if (ee_load) begin
			next_station = ee_station_address; // [R2]
		end
		next_rdata = get_byte(next_rd_base, next_rd_pos, next_rctl, next_station, next_htable);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rctl <= mraf_pkg::RCTL_RESET; // [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11]
			station <= mraf_pkg::STATION_RESET;
			htable <= mraf_pkg::HASH_RESET;
			stage <= 64'h0000_0000_0000_0000;
			stage_cnt <= 4'h0;
			rd_base <= mraf_pkg::CMD_ABORT;
			rd_pos <= 4'h0;
			sfr_rdata <= 8'h00;
		end else begin
			rctl <= next_rctl;
			station <= next_station;
			htable <= next_htable;
			stage <= next_stage;
			stage_cnt <= next_stage_cnt;
			rd_base <= next_rd_base;
			rd_pos <= next_rd_pos;
			sfr_rdata <= next_rdata;
		end
	end
	// Receive side
	mraf_pkg::mraf_rx_t st, next_st;
	logic [2:0] cnt, next_cnt;
	logic [31:0] crc, next_crc, crc_next;
	logic [47:0] da, next_da;
	logic [5:0] hash, next_hash;
	logic fire, fifo_ready, in_da;
	logic bcast, mcast, hit, uni_ok, addr_ok, dec_accept;
	logic [mraf_pkg::FIFO_WORD-1:0] fifo_out;
	// While stopped, bytes are swallowed so the datapath never hangs
	assign rx_ready = mac_run ? fifo_ready : 1'b1; // [R11]
	assign fire = rx_valid & rx_ready;
	assign in_da = st != mraf_pkg::MRAF_BODY;
	assign crc_next = crc_byte(st == mraf_pkg::MRAF_IDLE ? mraf_pkg::CRC_PRESET : crc, rx_data); // [R19]

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_crc = crc;
		next_da = da;
		next_hash = hash;
		if (!mac_run) begin
			next_st = mraf_pkg::MRAF_IDLE;
			next_cnt = 3'h0;
		end else if (fire) begin
			if (in_da) begin
				next_crc = crc_next; // [R12]
				next_da[{cnt, 3'b000} +: 8] = rx_data;
				next_cnt = cnt + 3'h1;
				if (cnt == mraf_pkg::DA_LAST) begin
					next_hash = crc_next[31:26]; // [R12]
				end
			end
			unique case (st)
				mraf_pkg::MRAF_IDLE: next_st = rx_last ? mraf_pkg::MRAF_IDLE : mraf_pkg::MRAF_ADDR;
				mraf_pkg::MRAF_ADDR: begin
					if (rx_last) begin
						next_st = mraf_pkg::MRAF_IDLE;
					end else if (cnt == mraf_pkg::DA_LAST) begin
						next_st = mraf_pkg::MRAF_BODY;
					end
				end
				mraf_pkg::MRAF_BODY: if (rx_last) next_st = mraf_pkg::MRAF_IDLE;
			endcase
			if (next_st == mraf_pkg::MRAF_IDLE) begin
				next_cnt = 3'h0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= mraf_pkg::MRAF_IDLE;
			cnt <= 3'h0;
			crc <= mraf_pkg::CRC_PRESET;
			da <= 48'h0000_0000_0000;
			hash <= 6'h00;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			crc <= next_crc;
			da <= next_da;
			hash <= next_hash;
		end
	end
	// Verdict, valid on the last byte of a frame past its address
	assign bcast = &da; // [R17]
	assign mcast = da[0] & ~bcast; // [R16]
	assign hit = htable[hash]; // [R13] [R14]
	assign uni_ok = (da == station) | (rctl[mraf_pkg::BIT_HUC] & hit); // [R3] [R9]
	always_comb begin
		if (rctl[mraf_pkg::BIT_EVERY]) begin
			addr_ok = 1'b1; // [R4]
		end else if (bcast) begin
			addr_ok = rctl[mraf_pkg::BIT_BCAST]; // [R7]
		end else if (mcast) begin
			addr_ok = rctl[mraf_pkg::BIT_ALL_MCAST] | (rctl[mraf_pkg::BIT_HMC] & hit); // [R5] [R8] [R18]
		end else begin
			addr_ok = uni_ok; // [R3]
		end
	end
	assign dec_accept = st == mraf_pkg::MRAF_BODY && addr_ok && !rx_pause // [R15]
		&& (!rx_crc_err || rctl[mraf_pkg::BIT_KEEP]); // [R6]
	mraf_fifo #(
		.WIDTH(mraf_pkg::FIFO_WORD),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rstn(rstn),
		.flush(~mac_run), // [R11]
		.in_valid(rx_valid & mac_run),
		.in_ready(fifo_ready),
		.in_data({dec_accept & rx_last, rx_last, rx_data}),
		.out_valid(pkt_valid),
		.out_ready(pkt_ready),
		.out_data(fifo_out)
	);
	assign pkt_data = fifo_out[7:0];
	assign pkt_last = fifo_out[8];
	assign pkt_accept = fifo_out[9];
	chk_pause_reject: assert property (@(posedge clock) disable iff (!rstn) // [R15]
		fire && rx_last && rx_pause |-> !dec_accept) else $error("pause frame accepted");
	chk_crc_drop: assert property (@(posedge clock) disable iff (!rstn) // [R6]
		fire && rx_last && rx_crc_err && !rctl[mraf_pkg::BIT_KEEP] |-> !dec_accept)
		else $error("crc error frame kept");
	chk_prom_pass: assert property (@(posedge clock) disable iff (!rstn) // [R4]
		fire && rx_last && st == mraf_pkg::MRAF_BODY && rctl[mraf_pkg::BIT_EVERY] && !rx_pause
		&& !rx_crc_err |-> dec_accept) else $error("promiscuous frame dropped");
	chk_bcast_block: assert property (@(posedge clock) disable iff (!rstn) // [R7]
		fire && rx_last && (&da) && !rctl[mraf_pkg::BIT_BCAST] && !rctl[mraf_pkg::BIT_EVERY]
		|-> !dec_accept) else $error("broadcast accepted while disabled");
	chk_mcast_hash: assert property (@(posedge clock) disable iff (!rstn) // [R18]
		fire && rx_last && mcast && !rctl[mraf_pkg::BIT_EVERY] && !rctl[mraf_pkg::BIT_ALL_MCAST]
		&& !(rctl[mraf_pkg::BIT_HMC] && htable[hash]) |-> !dec_accept)
		else $error("multicast passed without hash hit");
	chk_uni_exact: assert property (@(posedge clock) disable iff (!rstn) // [R3]
		fire && rx_last && !da[0] && da != station && !rctl[mraf_pkg::BIT_EVERY]
		&& !rctl[mraf_pkg::BIT_HUC] |-> !dec_accept) else $error("foreign unicast accepted");
	chk_hash_latch: assert property (@(posedge clock) disable iff (!rstn) // [R12]
		mac_run && fire && st == mraf_pkg::MRAF_ADDR && cnt == mraf_pkg::DA_LAST
		|=> hash == $past(crc_next[31:26]) && st != mraf_pkg::MRAF_ADDR)
		else $error("hash not latched on last address byte");
	chk_stop_flush: assert property (@(posedge clock) disable iff (!rstn) // [R11]
		!mac_run ##1 !mac_run |-> !pkt_valid && rx_ready) else $error("buffer not reset while stopped");
	chk_ee_load: assert property (@(posedge clock) disable iff (!rstn) // [R2]
		ee_load |=> station == $past(ee_station_address)) else $error("station address not loaded");
endmodule

`default_nettype wire

// ### src/mraf_pkg.sv
// Constants and types of the receive address filter
package mraf_pkg;
	// Indirect access port
	localparam logic [7:0] SFR_INDEX = 8'hB6;
	localparam logic [7:0] SFR_DATA = 8'hB7;
	localparam logic [7:0] CMD_ABORT = 8'hFF;
	// Register indexes behind the indirect port
	localparam logic [7:0] REG_RCTL = 8'h0A;
	localparam logic [7:0] REG_STATION = 8'h10;
	localparam logic [7:0] REG_HASH = 8'h16;
	localparam int RCTL_BYTES = 1;
	localparam int STATION_BYTES = 6;
	localparam int HASH_BYTES = 8;
	localparam int STAGE_BYTES = 8;
	// Receive control layout and reset value
	localparam logic [7:0] RCTL_RESET = 8'h58;
	localparam int BIT_EVERY = 0;
	localparam int BIT_ALL_MCAST = 1;
	localparam int BIT_KEEP = 2;
	localparam int BIT_BCAST = 3;
	localparam int BIT_HMC = 4;
	localparam int BIT_HUC = 5;
	localparam int BIT_RES1 = 6;
	localparam int BIT_RUN = 7;
	localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;
	localparam logic [63:0] HASH_RESET = 64'h0000_0000_0000_0000;
	// Destination hashing
	localparam logic [2:0] DA_LAST = 3'h5;
	localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
	localparam logic [31:0] CRC_PRESET = 32'hFFFF_FFFF;
	localparam int FIFO_WORD = 10;
	typedef enum logic [1:0] {
		MRAF_IDLE = 2'b00,
		MRAF_ADDR = 2'b01,
		MRAF_BODY = 2'b11
	} mraf_rx_t;
endpackage

// ### bench/mraf_rx_source.sv
// Receive datapath model that streams frames into the filter
`timescale 1ns/100ps
`default_nettype none

module mraf_rx_source (
	input wire logic clock,
	input wire logic go,
	input wire logic slow,
	input wire logic [4:0] len,
	input wire logic [191:0] frame,
	input wire logic crc_err,
	input wire logic pause,
	output logic busy = 1'b0,
	output logic rx_valid = 1'b0,
	input wire logic rx_ready,
	output logic [7:0] rx_data = 8'h00,
	output logic rx_last = 1'b0,
	output logic rx_crc_err = 1'b0,
	output logic rx_pause = 1'b0
);
	int seed = 35;
	always @(posedge clock) begin
		if (go) begin
			busy <= 1'b1;
			for (int i = 0; i < int'(len); i++) begin
				// Idle gaps show a toggling line, not the last byte
				while (slow && $random(seed) % 2 != 0) begin
					rx_valid <= 1'b0;
					rx_data <= ~rx_data;
					@(posedge clock);
				end
				rx_valid <= 1'b1;
				rx_data <= frame[8*i+:8];
				rx_last <= i == int'(len) - 1;
				rx_crc_err <= crc_err && i == int'(len) - 1;
				rx_pause <= pause && i == int'(len) - 1;
				// Byte and flags stay up until taken
				do @(posedge clock); while (rx_ready !== 1'b1);
			end
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
			rx_last <= 1'b0;
			rx_crc_err <= 1'b0;
			rx_pause <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ### bench/mraf_filter_tb.sv
// Self-checking bench for the receive address filter
`timescale 1ns/100ps
`default_nettype none

module mraf_filter_tb;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic ee_load = 1'b0;
	logic [47:0] ee_station_address = 48'h0000_0000_0000;
	logic pkt_ready = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic crc_err = 1'b0;
	logic pause = 1'b0;
	logic stall = 1'b0;
	logic [4:0] len = 5'h07;
	logic [191:0] frame = '0;
	logic [7:0] sfr_rdata, rx_data, pkt_data, rc;
	logic rx_valid, rx_ready, rx_last, rx_crc_err, rx_pause, pkt_valid, pkt_last, pkt_accept;
	logic mac_run, busy;
	logic [47:0] sa, da;
	logic [63:0] tbl, got;
	logic [9:0] exp_q[$];
	int seed = 35;
	int errors = 0;
	int checked = 0;
	always #50 clock = ~clock;
	mraf_filter #(.FIFO_DEPTH(16)) dut (.clock(clock), .rstn(rstn), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.ee_load(ee_load), .ee_station_address(ee_station_address), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last), .rx_crc_err(rx_crc_err),
		.rx_pause(rx_pause), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
		.pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_accept(pkt_accept), .mac_run(mac_run));
	mraf_rx_source src (.clock(clock), .go(go), .slow(slow), .len(len), .frame(frame),
		.crc_err(crc_err), .pause(pause), .busy(busy), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
		.rx_crc_err(rx_crc_err), .rx_pause(rx_pause));
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task sfr_pulse(input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_wr <= !rd;
		sfr_rd <= rd;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clock);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		#1;
	endtask
	task reg_write(input logic [7:0] idx, input logic [63:0] v, input int n);
		for (int j = 0; j < n; j++)
			sfr_pulse(1'b0, mraf_pkg::SFR_DATA, v[8*j+:8]);
		sfr_pulse(1'b0, mraf_pkg::SFR_INDEX, idx);
	endtask
	task reg_read(input logic [7:0] idx, input int n, output logic [63:0] v);
		v = '0;
		sfr_pulse(1'b0, mraf_pkg::SFR_INDEX, idx);
		for (int j = 0; j < n; j++) begin
			v[8*j+:8] = sfr_rdata;
			sfr_pulse(1'b1, mraf_pkg::SFR_DATA, 8'h00);
		end
	endtask
	function automatic logic [5:0] hash_of(input logic [47:0] d);
		logic [31:0] c;
		c = mraf_pkg::CRC_PRESET;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? mraf_pkg::CRC_POLY : 32'h0000_0000);
		return c[31:26];
	endfunction
	function automatic logic accept_of(input logic [7:0] c, input logic [47:0] d);
		logic hit;
		hit = tbl[hash_of(d)];
		if (pause || (crc_err && !c[2]))
			return 1'b0;
		if (c[0])
			return 1'b1;
		if (d == 48'hFFFF_FFFF_FFFF)
			return c[3];
		if (d[0])
			return c[1] || (c[4] && hit);
		return d == sa || (c[5] && hit);
	endfunction
	task send_frame(input logic out, input logic acc);
		for (int i = 0; i < int'(len); i++)
			if (out)
				exp_q.push_back({i == int'(len) - 1, acc && i == int'(len) - 1, frame[8*i+:8]});
		@(posedge clock);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
	endtask
	task wait_idle;
		for (int k = 0; k < 4000; k++) begin
			@(posedge clock);
			if (busy === 1'b0 && exp_q.size() == 0)
				return;
		end
		errors++;
		$display("Wait limit reached at %0t", $time);
		give_verdict();
	endtask
	// Verdict rides only on the last word of each frame
	always @(posedge clock) begin
		pkt_ready <= !stall && $random(seed) % 4 != 0;
		if (rstn && pkt_valid === 1'b1 && pkt_ready)
			check({pkt_last, pkt_accept, pkt_data},
				exp_q.size() ? exp_q.pop_front() : 64'hFFFF_FFFF_FFFF_FFFF);
	end
	initial begin
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		reg_read(mraf_pkg::REG_RCTL, 1, got);
		check(got, 64'h0000_0000_0000_0058);
		reg_read(mraf_pkg::REG_STATION, 6, got);
		check(got, 64'h0000_0000_0000_0000);
		sa = 48'({$random(seed), $random(seed)});
		sa[0] = 1'b0;
		ee_station_address <= sa;
		ee_load <= 1'b1;
		@(posedge clock);
		ee_load <= 1'b0;
		reg_read(mraf_pkg::REG_STATION, 6, got);
		check(got, {16'h0000, sa});
		tbl = {$random(seed), $random(seed)};
		reg_write(mraf_pkg::REG_HASH, tbl, 8);
		reg_read(mraf_pkg::REG_HASH, 8, got);
		check(got, tbl);
		// Abort must drop the queued byte instead of committing it
		sfr_pulse(1'b0, mraf_pkg::SFR_DATA, 8'h00);
		sfr_pulse(1'b0, mraf_pkg::SFR_INDEX, mraf_pkg::CMD_ABORT);
		reg_read(mraf_pkg::REG_RCTL, 1, got);
		check(got, 64'h0000_0000_0000_0058);
		for (int n = 0; n < 40; n++) begin
			rc = {2'b11, 6'($random(seed))};
			reg_write(mraf_pkg::REG_RCTL, {56'h0, rc}, 1);
			check(mac_run, 1'b1);
			case ($random(seed) & 3)
				0: da = sa;
				1: da = 48'hFFFF_FFFF_FFFF;
				default: da = 48'({$random(seed), $random(seed)});
			endcase
			frame = {6{$random(seed)}};
			frame[47:0] = da;
			len = 5'(7 + ($random(seed) & 15));
			crc_err = ($random(seed) & 3) == 0;
			pause = ($random(seed) & 7) == 0;
			slow = 1'($random(seed));
			send_frame(1'b1, accept_of(rc, da));
			wait_idle();
		end
		// Fill the buffer with the far side stalled, then drain it
		stall <= 1'b1;
		len = 5'h18;
		crc_err = 1'b0;
		pause = 1'b0;
		send_frame(1'b1, accept_of(rc, da));
		for (int k = 0; k < 200 && rx_ready !== 1'b0; k++)
			@(posedge clock);
		check(rx_ready, 1'b0);
		stall <= 1'b0;
		wait_idle();
		// Stop with bytes held in the buffer; none of them may come out
		stall <= 1'b1;
		send_frame(1'b0, 1'b0);
		for (int k = 0; k < 200 && rx_ready !== 1'b0; k++)
			@(posedge clock);
		reg_write(mraf_pkg::REG_RCTL, 64'h0000_0000_0000_0058, 1);
		check(mac_run, 1'b0);
		wait_idle();
		stall <= 1'b0;
		send_frame(1'b0, 1'b0);
		wait_idle();
		repeat (5) @(posedge clock);
		check(rx_ready, 1'b1);
		check(pkt_valid, 1'b0);
		give_verdict();
	end
endmodule

`default_nettype wire
